// ---- rtl/ees_latch.sv ----
// One sticky event latch with its enable mask and summary bit.
// Assumes event pulses last one cycle; clear and load strobes come from top.
module ees_latch
	import ees_pkg::*;
#(
	parameter int W = EES_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] evt_pulse,
	input wire logic clr,
	input wire logic mask_ld,
	input wire logic [W-1:0] mask_val,
	output logic [W-1:0] latch_q,
	output logic [W-1:0] mask_q,
	output logic summary
);
	typedef struct packed {
		logic [W-1:0] latch;
		logic [W-1:0] mask;
	} ees_lat_st_t;

	ees_lat_st_t st_ff;
	ees_lat_st_t nxt_st;
	logic [W-1:0] evt_ok;

	always_comb begin
		evt_ok = evt_pulse & EES_EVT_MASK[W-1:0];
		nxt_st = st_ff;
		// Clear first, then events, so a same-cycle event survives
		if (clr) begin
			nxt_st.latch = '0;
		end
		nxt_st.latch = nxt_st.latch | evt_ok;
		if (mask_ld) begin
			nxt_st.mask = mask_val;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign latch_q = st_ff.latch;
	assign mask_q = st_ff.mask;
	assign summary = |(st_ff.latch & st_ff.mask);
endmodule : ees_latch

// ---- rtl/ees_top.sv ----
// Extended event status: failure and completion latches, their masks,
// status byte summary bits and the operation-complete handshake.
// Assumes one decoded command per REQ_VALID pulse from the message parser.
module ees_top
	import ees_pkg::*;
#(
	parameter int W = EES_W
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic REQ_VALID,
	input wire ees_req_t REQ,
	input wire logic [W-1:0] FAIL_EVT,
	input wire logic [W-1:0] DONE_EVT,
	input wire logic [7:0] SRQ_ENABLE,
	output logic REQ_READY,
	output ees_rsp_t RSP,
	output logic [7:0] STB_PART,
	output logic OPC_SET,
	output logic SRQ
);
	typedef struct packed {
		logic ready;
		ees_rsp_t rsp;
		logic [7:0] stb;
		logic opc;
		logic srq;
	} ees_top_st_t;

	ees_top_st_t st_ff;
	ees_top_st_t nxt_st;
	logic take;
	logic clr_fail, clr_done, ld_fail, ld_done;
	logic [W-1:0] fail_q, done_q, fmask_q, dmask_q;
	logic fail_sum, done_sum;

	// One request taken per cycle with READY high
	assign take = REQ_VALID && st_ff.ready;

	always_comb begin
		clr_fail = 1'b0;
		clr_done = 1'b0;
		ld_fail = 1'b0;
		ld_done = 1'b0;
		if (take) begin
			unique case (REQ.code)
				EES_CMD_CLS: begin
					clr_fail = 1'b1;
					clr_done = 1'b1;
				end
				EES_CMD_RD_LATCH_A: clr_fail = 1'b1;
				EES_CMD_RD_LATCH_B: clr_done = 1'b1;
				EES_CMD_WR_MASK_A: ld_fail = 1'b1;
				EES_CMD_WR_MASK_B: ld_done = 1'b1;
				default: begin
					// Reset and device clear leave masks alone
					clr_fail = 1'b0;
				end
			endcase
		end
	end

	ees_latch #(.W(W)) u_fail (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.evt_pulse(FAIL_EVT),
		.clr(clr_fail),
		.mask_ld(ld_fail),
		.mask_val(REQ.data[W-1:0]),
		.latch_q(fail_q),
		.mask_q(fmask_q),
		.summary(fail_sum)
	);

	ees_latch #(.W(W)) u_done (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.evt_pulse(DONE_EVT),
		.clr(clr_done),
		.mask_ld(ld_done),
		.mask_val(REQ.data[W-1:0]),
		.latch_q(done_q),
		.mask_q(dmask_q),
		.summary(done_sum)
	);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rsp = '0;
		nxt_st.opc = 1'b0;
		// Each request takes two cycles, so the next waits its turn
		nxt_st.ready = !take;
		if (take) begin
			unique case (REQ.code)
				// Latches answer with pre-clear value; writes have no path
				EES_CMD_RD_LATCH_A: nxt_st.rsp = '{1'b1, 8'(fail_q)};
				EES_CMD_RD_LATCH_B: nxt_st.rsp = '{1'b1, 8'(done_q)};
				EES_CMD_RD_MASK_A: nxt_st.rsp = '{1'b1, 8'(fmask_q)};
				EES_CMD_RD_MASK_B: nxt_st.rsp = '{1'b1, 8'(dmask_q)};
				EES_CMD_OPC_Q: nxt_st.rsp = '{1'b1, EES_OPC_RESP};
				EES_CMD_OPC: nxt_st.opc = 1'b1;
				default: nxt_st.rsp = '0;
			endcase
		end
		nxt_st.stb = 8'h00;
		nxt_st.stb[EES_STB_END] = done_sum;
		nxt_st.stb[EES_STB_ERR] = fail_sum;
		nxt_st.srq = |(nxt_st.stb & SRQ_ENABLE);
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign REQ_READY = st_ff.ready;
	assign RSP = st_ff.rsp;
	assign STB_PART = st_ff.stb;
	assign OPC_SET = st_ff.opc;
	assign SRQ = st_ff.srq;
endmodule : ees_top

// ---- shared/ees_pkg.sv ----
// Package for the extended event status block: command codes, bit layout,
// reset values and the carrier structs used by ees_top and the verification models.
// Assumes a command decoder upstream that has already parsed messages.
package ees_pkg;
	localparam int EES_W = 8;
	localparam logic [7:0] EES_RST = 8'h00;
	// Defined event bits; bit 1 is unused in both latches
	localparam logic [7:0] EES_EVT_MASK = 8'hFD;
	localparam int EES_BIT_FREQ = 0;
	localparam int EES_BIT_LEVEL = 2;
	localparam int EES_BIT_MEAS = 3;
	localparam int EES_BIT_WAVE = 4;
	localparam int EES_BIT_FILE = 5;
	localparam int EES_BIT_MOPT = 6;
	localparam int EES_BIT_MCHK = 7;
	// Status byte positions of the summaries
	localparam int EES_STB_END = 2;
	localparam int EES_STB_ERR = 3;
	// Standard event operation-complete bit
	localparam int EES_SESR_OPC = 0;
	localparam logic [7:0] EES_OPC_RESP = 8'h01;

	typedef enum logic [3:0] {
		EES_CMD_NONE,
		EES_CMD_CLS,
		EES_CMD_RST,
		EES_CMD_DCL,
		EES_CMD_RD_LATCH_A,
		EES_CMD_RD_LATCH_B,
		EES_CMD_RD_MASK_A,
		EES_CMD_RD_MASK_B,
		EES_CMD_WR_MASK_A,
		EES_CMD_WR_MASK_B,
		EES_CMD_OPC,
		EES_CMD_OPC_Q
	} ees_cmd_t;

	typedef struct packed {
		ees_cmd_t code;
		logic [7:0] data;
	} ees_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ees_rsp_t;
endpackage : ees_pkg

// ---- verif/ees_ctl.sv ----
// Remote controller model sending one decoded command at a time.
// Assumes the answer comes one cycle after the take.
module ees_ctl
	import ees_pkg::*;
(
	input wire logic clk,
	input wire logic rdy,
	input wire ees_rsp_t rsp,
	output logic vld,
	output ees_req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {vld, req} = '0;
	task send(ees_cmd_t c, logic [7:0] d, output ees_rsp_t q);
		@(negedge clk);
		while (rdy !== 1'b1) @(negedge clk);
		vld = 1;
		req = '{c, d};
		@(negedge clk);
		q = rsp;
		vld = 0;
		req = '{EES_CMD_NONE, ~d};
	endtask : send
endmodule : ees_ctl

// ---- verif/ees_sva.sv ----
// Port assertions for the event status block.
// Bound onto ees_top; one clock, reset async low.
module ees_sva
	import ees_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic REQ_VALID,
	input wire ees_req_t REQ,
	input wire logic [7:0] FAIL_EVT,
	input wire logic [7:0] SRQ_ENABLE,
	input wire logic REQ_READY,
	input wire ees_rsp_t RSP,
	input wire logic [7:0] STB_PART,
	input wire logic OPC_SET,
	input wire logic SRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	wire tk = REQ_VALID && REQ_READY;
	wire ees_cmd_t cd = REQ.code;
	property p_spr; (STB_PART & 8'hF3) == 0; endproperty
	a_spr: assert property (p_spr) else $error("spare");
	property p_oq; tk && cd == EES_CMD_OPC_Q |=> RSP == 9'h101; endproperty
	a_oq: assert property (p_oq) else $error("opcq");
	property p_op; tk && cd == EES_CMD_OPC |=> OPC_SET; endproperty
	a_op: assert property (p_op) else $error("opc");
	property p_rdy; tk |=> !REQ_READY; endproperty
	a_rdy: assert property (p_rdy) else $error("rdy");
	property p_rsp; RSP.valid |-> $past(tk); endproperty
	a_rsp: assert property (p_rsp) else $error("rsp");
	property p_srq; $stable(SRQ_ENABLE)
		|-> SRQ == |(STB_PART & SRQ_ENABLE); endproperty
	a_srq: assert property (p_srq) else $error("srq");
	property p_mz; tk && cd == EES_CMD_WR_MASK_A && REQ.data == 0
		|-> ##2 !STB_PART[EES_STB_ERR]; endproperty
	a_mz: assert property (p_mz) else $error("mask");
	property p_cls; tk && cd == EES_CMD_CLS && FAIL_EVT == 0
		|-> ##2 !STB_PART[EES_STB_ERR]; endproperty
	a_cls: assert property (p_cls) else $error("cls");
	c_srq: cover property (SRQ);
	c_opc: cover property (OPC_SET);
	c_cls: cover property (tk && cd == EES_CMD_CLS);
endmodule : ees_sva
bind ees_top ees_sva u_sva(.SYS_CLK, .NRST, .REQ_VALID, .REQ, .FAIL_EVT,
	.SRQ_ENABLE, .REQ_READY, .RSP, .STB_PART, .OPC_SET, .SRQ);

// ---- verif/ees_top_bench.sv ----
// Bench for the event status block: commands, event pulses, checks.
// Assumes the controller model drives all requests.
module ees_top_bench
	import ees_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic nrst = 0;
	logic vld, rdy, opc, srq;
	logic [7:0] fe = 0, de = 0, se = 0, stb;
	ees_req_t req;
	ees_rsp_t rsp, q;
	int error_cnt = 0, num_checks = 0;
	always #4 clk = ~clk;
	ees_top DUT(.SYS_CLK(clk), .NRST(nrst), .REQ_VALID(vld), .REQ(req),
		.FAIL_EVT(fe), .DONE_EVT(de), .SRQ_ENABLE(se), .REQ_READY(rdy),
		.RSP(rsp), .STB_PART(stb), .OPC_SET(opc), .SRQ(srq));
	ees_ctl ctl(.clk, .rdy, .rsp, .vld, .req);
	task chk(string n, logic [8:0] s, logic [8:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task io(ees_cmd_t c, logic [7:0] d, logic [8:0] e);
		ctl.send(c, d, q);
		if (e[8])
			chk("rsp", q, e);
	endtask : io
	task ev(logic [7:0] f, logic [7:0] d);
		fe = f;
		de = d;
		@(negedge clk);
		{fe, de} = 0;
		repeat (2) @(negedge clk);
	endtask : ev
	task stop_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge clk);
		nrst = 1;
		io(EES_CMD_RD_MASK_A, 0, 9'h100);
		io(EES_CMD_WR_MASK_A, 8'hFD, 0);
		se = 8'h08;
		ev(8'hFF, 8'hFF);
		chk("stb", stb, 9'h008);
		chk("srq", srq, 9'h001);
		io(EES_CMD_RD_LATCH_A, 0, 9'h1FD);
		io(EES_CMD_RD_LATCH_A, 0, 9'h100);
		$display("test 1 end");
		io(EES_CMD_WR_MASK_B, 8'h04, 0);
		@(negedge clk);
		chk("stb", stb, 9'h004);
		io(EES_CMD_RD_LATCH_B, 0, 9'h1FD);
		ev(8'h00, 8'h81);
		io(EES_CMD_CLS, 0, 0);
		io(EES_CMD_RST, 0, 0);
		io(EES_CMD_DCL, 0, 0);
		io(EES_CMD_RD_LATCH_B, 0, 9'h100);
		io(EES_CMD_RD_MASK_B, 0, 9'h104);
		io(EES_CMD_RD_MASK_B, 0, 9'h104);
		io(EES_CMD_RD_MASK_A, 0, 9'h1FD);
		io(EES_CMD_WR_MASK_A, 0, 0);
		io(EES_CMD_RD_MASK_A, 0, 9'h100);
		io(EES_CMD_OPC_Q, 0, 9'h101);
		io(EES_CMD_OPC, 0, 0);
		chk("opc", opc, 9'h001);
		$display("test 2 end");
		stop_test();
	end
endmodule : ees_top_bench
